// ### verif/smms_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module smms_ctrl_model (
	input  wire logic        clk,      // System clock
	output var  logic [6:0]  diOut,    // Select inputs, high = contact on
	output var  logic [15:0] pulseOut  // Pulse position command
);
	initial begin
		diOut = 7'h00;
		pulseOut = 16'h0000;
	end
	// Select levels change just after an edge; no trigger strobe exists
	task automatic setDi(input logic [6:0] bits, input logic [15:0] pulse);
		@(posedge clk);
		#1;
		diOut = bits;
		pulseOut = pulse;
	endtask
endmodule // smms_ctrl_model
`default_nettype wire

// ### verif/smms_mode_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "smms_defines.vh"

module smms_mode_select_chk (
	input wire logic        clk,               // System clock
	input wire logic        rst_n,             // Reset, active low
	input wire logic [7:0]  modeSetting,       // Mode code
	input wire logic [15:0] maxSpeedSetting,   // Speed clamp
	input wire logic        speedPosSel,       // Speed/position select
	input wire logic        torquePosSel,      // Torque/position select
	input wire logic        speedTorqueSel,    // Speed/torque select
	input wire logic [2:0]  ctrlMode,          // Active mode
	input wire logic        dioMapValid,       // Mapping valid
	input wire logic [15:0] positionCmd,       // Position command
	input wire logic [15:0] speedCmd,          // Speed command
	input wire logic [15:0] torqueCmd,         // Torque command
	input wire logic        speedLimitActive,  // Speed limit on
	input wire logic        torqueLimitActive, // Torque limit on
	input wire logic [15:0] monitorChannelOne, // Monitor one
	input wire logic [15:0] monitorChannelTwo  // Monitor two
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Held selects; five cycles cover sync plus output stage
	// ----------------------------------------
	sequence ptSpeedOn; (modeSetting == `SMMS_CODE_PT_S && speedPosSel) [*5]; endsequence
	sequence ptTorqueOn; (modeSetting == `SMMS_CODE_PT_T && torquePosSel) [*5]; endsequence
	sequence stOn; (modeSetting == `SMMS_CODE_S_T && speedTorqueSel) [*5]; endsequence
	sequence stOff; (modeSetting == `SMMS_CODE_S_T && !speedTorqueSel) [*5]; endsequence
	pt_speed_a: assert property (ptSpeedOn |=> ctrlMode == 3'b010)
		else $error("position/speed dual did not enter speed");
	pt_torque_a: assert property (ptTorqueOn |=> ctrlMode == 3'b100)
		else $error("position/torque dual did not enter torque");
	st_torque_a: assert property (stOn |=> ctrlMode == 3'b100)
		else $error("speed/torque dual did not enter torque");
	st_speed_a: assert property (stOff |=> ctrlMode == 3'b010)
		else $error("speed/torque dual did not enter speed");
	speed_clamp_a: assert property ($signed(speedCmd) <= $signed({1'b0, $past(maxSpeedSetting)})
		&& $signed(speedCmd) >= -$signed({1'b0, $past(maxSpeedSetting)})) else $error("speed above clamp");
	slimit_mode_a: assert property (speedLimitActive |-> ctrlMode == 3'b100)
		else $error("speed limit outside torque mode");
	tlimit_mode_a: assert property (torqueLimitActive |-> ctrlMode != 3'b100)
		else $error("torque limit in torque mode");
	pos_cmd_a: assert property (ctrlMode != 3'b001 |-> positionCmd == 16'h0000)
		else $error("position command outside position mode");
	trq_cmd_a: assert property (ctrlMode != 3'b100 |-> torqueCmd == 16'h0000)
		else $error("torque command outside torque mode");
	mon_range_a: assert property ($signed(monitorChannelOne) <= 16'sh1F40 && $signed(monitorChannelOne) >= -16'sh1F40
		&& $signed(monitorChannelTwo) <= 16'sh1F40 && $signed(monitorChannelTwo) >= -16'sh1F40) else $error("monitor out of range");
	map_valid_a: assert property (dioMapValid |-> $past(modeSetting, 2) inside {8'h00, 8'h02, 8'h03,
		8'h04, 8'h05, 8'h06, 8'h07, 8'h0A}) else $error("mapping valid for bad code");
endmodule // smms_mode_select_chk

bind smms_mode_select smms_mode_select_chk u_chk (.clk(clk), .rst_n(rst_n), .modeSetting(modeSetting),
	.maxSpeedSetting(maxSpeedSetting), .speedPosSel(speedPosSel), .torquePosSel(torquePosSel),
	.speedTorqueSel(speedTorqueSel), .ctrlMode(ctrlMode), .dioMapValid(dioMapValid), .positionCmd(positionCmd),
	.speedCmd(speedCmd), .torqueCmd(torqueCmd), .speedLimitActive(speedLimitActive),
	.torqueLimitActive(torqueLimitActive), .monitorChannelOne(monitorChannelOne),
	.monitorChannelTwo(monitorChannelTwo));
`default_nettype wire

// ### verif/smms_mode_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "smms_defines.vh"

module smms_mode_select_tb;
	logic        clk, rst_n, speedLimitEnable, torqueLimitEnable, regWrite, regRead;
	logic [7:0]  modeSetting;
	logic [15:0] maxSpeedSetting, analogSpeed, analogTorque, motorSpeed, motorTorque, dcBusVoltage, pulseFreq;
	logic [15:0] maxTorque, maxPulseFreq, maxBusVoltage, regAddr, regWrData, torquePreset1;
	wire  [6:0]  di;
	wire  [2:0]  ctrlMode;
	wire         dioMapValid, speedLimitActive, torqueLimitActive;
	wire  [15:0] pulseCmd, regRdData, positionCmd, speedCmd, torqueCmd, speedLimit, torqueLimit, monOne, monTwo;
	int          errors, n_checks, i;
	logic [7:0]  codes [6] = '{8'h06, 8'h06, 8'h07, 8'h07, 8'h0A, 8'h0A};
	logic [2:0]  modes [6] = '{3'b001, 3'b010, 3'b001, 3'b100, 3'b010, 3'b100};
	int          swBit [6] = '{4, 4, 5, 5, 6, 6};
	longint      qs [7] = '{1000, -500, 100, 1500, 0, 300, 0};
	longint      mx [7] = '{3000, 1000, 450, 3000, 1000, 450, 1};

	smms_ctrl_model u_smms_ctrl_model (.clk(clk), .diOut(di), .pulseOut(pulseCmd));
	smms_mode_select u_smms_mode_select (.clk(clk), .rst_n(rst_n), .modeSetting(modeSetting),
		.speedLimitEnable(speedLimitEnable), .torqueLimitEnable(torqueLimitEnable), .maxSpeedSetting(maxSpeedSetting),
		.speedSelBit0(di[0]), .speedSelBit1(di[1]), .torqueSelBit0(di[2]), .torqueSelBit1(di[3]),
		.speedPosSel(di[4]), .torquePosSel(di[5]), .speedTorqueSel(di[6]), .analogSpeed(analogSpeed),
		.analogTorque(analogTorque), .speedPreset1(16'h0064), .speedPreset2(16'h04B0), .speedPreset3(16'h0320),
		.torquePreset1(torquePreset1), .torquePreset2(16'h0234), .torquePreset3(16'h0456), .pulseCmd(pulseCmd),
		.pulseFreq(pulseFreq), .motorSpeed(motorSpeed), .motorTorque(motorTorque), .dcBusVoltage(dcBusVoltage),
		.maxTorque(maxTorque), .maxPulseFreq(maxPulseFreq), .maxBusVoltage(maxBusVoltage), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .ctrlMode(ctrlMode),
		.dioMapValid(dioMapValid), .positionCmd(positionCmd), .speedCmd(speedCmd), .torqueCmd(torqueCmd),
		.speedLimitActive(speedLimitActive), .speedLimit(speedLimit), .torqueLimitActive(torqueLimitActive),
		.torqueLimit(torqueLimit), .monitorChannelOne(monOne), .monitorChannelTwo(monTwo));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic regWr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1;
		regWrite = 1'b0;
	endtask
	task automatic regRd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		#1;
		regAddr = a;
		regRead = 1'b1;
		@(posedge clk);
		#1;
		regRead = 1'b0;
		chk(regRdData, exp);
	endtask
	// Fixed four-edge wait: select sync two edges plus output one, one spare
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	function automatic logic [15:0] monExp(input longint q, input longint m, input longint p);
		longint v;
		v = q * 800000 / (m * p);
		if (v > 8000) v = 8000;
		if (v < -8000) v = -8000;
		return v[15:0];
	endfunction
	task automatic final_report();
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		#100000;
		errors++;
		final_report();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, speedLimitEnable, torqueLimitEnable, regWrite, regRead} = 5'b00000;
		modeSetting = `SMMS_CODE_S;
		{maxSpeedSetting, analogSpeed, analogTorque} = {16'h0BB8, 16'h05DC, 16'h0200};
		{motorSpeed, motorTorque, dcBusVoltage, pulseFreq} = {16'h03E8, 16'hFE0C, 16'h012C, 16'h0064};
		{maxTorque, maxPulseFreq, maxBusVoltage, regAddr, regWrData} = {16'h03E8, 16'h01C2, 16'h01C2, 32'h0};
		torquePreset1 = 16'h0123;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		regRd(`SMMS_OFF_MON_SEL, 16'h0000);
		regRd(`SMMS_OFF_MONITOR_CHANNEL_ONE_PROP, 16'h0064);
		regRd(`SMMS_OFF_MONITOR_CHANNEL_TWO_PROP, 16'h0064);
		regRd(16'h0300, 16'h0000);
		regWr(`SMMS_OFF_MON_SEL, 16'h0031);
		regRd(`SMMS_OFF_MON_SEL, 16'h0031);
		for (i = 0; i < 6; i++) begin
			modeSetting = codes[i];
			u_smms_ctrl_model.setDi(7'b0000110 | (7'(i % 2) << swBit[i]), 16'h1234);
			settle();
			chk({13'h0, ctrlMode}, {13'h0, modes[i]});
			if (modes[i] == 3'b001) chk(positionCmd, 16'h1234);
			if (modes[i] == 3'b010) chk(speedCmd, 16'h04B0);
			if (modes[i] == 3'b100) chk(torqueCmd, 16'h0123);
		end
		torquePreset1 = 16'h0321;
		settle();
		chk(torqueCmd, 16'h0321);
		modeSetting = `SMMS_CODE_SZ;
		u_smms_ctrl_model.setDi(7'b0000000, 16'h0ABC);
		settle();
		chk(speedCmd, 16'h0000);
		modeSetting = `SMMS_CODE_PT;
		settle();
		chk(positionCmd, 16'h0ABC);
		modeSetting = `SMMS_CODE_TZ;
		u_smms_ctrl_model.setDi(7'b0000000, 16'h0000);
		settle();
		chk(torqueCmd, 16'h0000);
		modeSetting = `SMMS_CODE_T;
		settle();
		chk(torqueCmd, 16'h0200);
		speedLimitEnable = 1'b1;
		u_smms_ctrl_model.setDi(7'b0000010, 16'h0000);
		settle();
		chk({14'h0, speedLimitActive, torqueLimitActive}, 16'h0002);
		chk(speedLimit, 16'h04B0);
		modeSetting = `SMMS_CODE_S;
		torqueLimitEnable = 1'b1;
		u_smms_ctrl_model.setDi(7'b0001100, 16'h0000);
		settle();
		chk({14'h0, speedLimitActive, torqueLimitActive}, 16'h0001);
		chk(torqueLimit, 16'h0456);
		regRd(`SMMS_OFF_STATUS, 16'h0032);
		torqueLimitEnable = 1'b0;
		analogSpeed = 16'h1388;
		u_smms_ctrl_model.setDi(7'b0000000, 16'h0000);
		settle();
		chk({15'h0, torqueLimitActive}, 16'h0000);
		chk(speedCmd, 16'h0BB8);
		analogSpeed = 16'hEC78;
		settle();
		chk(speedCmd, 16'hF448);
		analogSpeed = 16'h05DC;
		regWr(`SMMS_OFF_MONITOR_CHANNEL_TWO_PROP, 16'h0032);
		for (i = 0; i < 7; i++) begin
			regWr(`SMMS_OFF_MON_SEL, {8'h00, 4'(i), 4'(6 - i)});
			settle();
			chk(monOne, (i == 6) ? 16'h0000 : monExp(qs[i], mx[i], 100));
			chk(monTwo, (i == 0) ? 16'h0000 : monExp(qs[6 - i], mx[6 - i], 50));
		end
		modeSetting = 8'h01;
		settle();
		chk({12'h0, dioMapValid, ctrlMode}, 16'h0001);
		modeSetting = `SMMS_CODE_S;
		settle();
		chk({15'h0, dioMapValid}, 16'h0001);
		final_report();
	end
endmodule // smms_mode_select_tb
`default_nettype wire

// ### verilog/smms_defines.vh
`ifndef SMMS_DEFINES_VH
`define SMMS_DEFINES_VH

// ----------------------------------------
// Control mode setting codes
// ----------------------------------------
`define SMMS_CODE_PT        8'h00
`define SMMS_CODE_S         8'h02
`define SMMS_CODE_T         8'h03
`define SMMS_CODE_SZ        8'h04
`define SMMS_CODE_TZ        8'h05
`define SMMS_CODE_PT_S      8'h06
`define SMMS_CODE_PT_T      8'h07
`define SMMS_CODE_S_T       8'h0A

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define SMMS_OFF_MON_SEL    16'h0006
`define SMMS_OFF_MONITOR_CHANNEL_ONE_PROP  16'h0108
`define SMMS_OFF_MONITOR_CHANNEL_TWO_PROP  16'h010A
`define SMMS_OFF_STATUS     16'h0200
`define SMMS_RST_MON_SEL    16'h0000
`define SMMS_RST_PROP       16'h0064

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMMS_MONITOR_CHANNEL_ONE_DIGIT     7:4
`define SMMS_MONITOR_CHANNEL_TWO_DIGIT     3:0
`define SMMS_DI_SPEED_SEL_BIT0        0
`define SMMS_DI_SPEED_SEL_BIT1        1
`define SMMS_DI_TORQUE_SEL_BIT0        2
`define SMMS_DI_TORQUE_SEL_BIT1        3
`define SMMS_DI_SP          4
`define SMMS_DI_TP          5
`define SMMS_DI_ST          6
`define SMMS_DI_WIDTH       7

// ----------------------------------------
// Monitor quantity codes and scaling
// ----------------------------------------
`define SMMS_MON_SPEED      4'h0
`define SMMS_MON_TORQUE     4'h1
`define SMMS_MON_PULSE      4'h2
`define SMMS_MON_SPD_CMD    4'h3
`define SMMS_MON_TRQ_CMD    4'h4
`define SMMS_MON_BUS        4'h5
// 8 V full scale in mV times the 100 of the percent proportion
`define SMMS_MON_NUM        40'h00000C3500
`define SMMS_MON_LIM_POS    40'sh0000001F40
`define SMMS_MON_LIM_NEG    40'shFFFFFFE0C0
`define SMMS_ZERO16         16'h0000

`endif

// ### verilog/smms_input_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "smms_defines.vh"

module smms_input_sync (
	input  wire                      clk,    // System clock
	input  wire                      rst_n,  // Asynchronous reset, active low
	input  wire [`SMMS_DI_WIDTH-1:0] din,    // Raw digital inputs
	output wire [`SMMS_DI_WIDTH-1:0] dout    // Synchronised inputs
);

	reg [`SMMS_DI_WIDTH-1:0] stage1;
	reg [`SMMS_DI_WIDTH-1:0] stage2;

	genvar i;
	generate
		for (i = 0; i < `SMMS_DI_WIDTH; i = i + 1) begin : gSync
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1[i] <= 1'b0;
					stage2[i] <= 1'b0;
				end else begin
					stage1[i] <= din[i];  // RL20
					stage2[i] <= stage1[i];
				end
			end
		end
	endgenerate

	assign dout = stage2;

endmodule // smms_input_sync
`default_nettype wire

// ### verilog/smms_mode_select.v
// Notes on behaviour
// RL1: Code 06 switches pulse position and speed
// RL2: Code 07 switches pulse position and torque
// RL3: Code 0A switches speed and torque
// RL4: First torque selection: zero variant 0, else analog
// RL5: Controller picks torque command after servo on
// RL6: No dual mode uses zero-command variants
// RL7: Speed/torque dual: select inputs pick sources
// RL8: Speed/torque select ON torque, OFF speed
// RL9: Speed/position dual: pulse position, analog/preset speed
// RL10: Torque/position dual: select switches, analog/preset torque
// RL11: Speed always clamped to maximum speed setting
// RL12: Speed limit only torque mode when enabled
// RL13: Torque limit only position/speed when enabled
// RL14: Monitor digit picks one of six quantities
// RL15: Upper digit channel one, lower channel two
// RL16: Monitor output scaled by max and proportion
// RL17: Pin mapping valid only after mode selected
// RL18: Select input off reads 0, on 1
// RL19: Preset selection acts at once, no trigger
// RL20: Select inputs synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "smms_defines.vh"

module smms_mode_select (
	input  wire        clk,               // System clock, 250 MHz
	input  wire        rst_n,             // Asynchronous reset, active low
	input  wire [7:0]  modeSetting,       // Control mode setting code
	input  wire        speedLimitEnable,  // Speed limit enable setting bit
	input  wire        torqueLimitEnable, // Torque limit enable setting bit
	input  wire [15:0] maxSpeedSetting,   // Maximum speed clamp
	input  wire        speedSelBit0,      // Speed command select 0
	input  wire        speedSelBit1,      // Speed command select 1
	input  wire        torqueSelBit0,     // Torque command select 0
	input  wire        torqueSelBit1,     // Torque command select 1
	input  wire        speedPosSel,       // Speed/position select, on = speed
	input  wire        torquePosSel,      // Torque/position select, on = torque
	input  wire        speedTorqueSel,    // Speed/torque select, on = torque
	input  wire [15:0] analogSpeed,       // Signed analog speed input
	input  wire [15:0] analogTorque,      // Signed analog torque input
	input  wire [15:0] speedPreset1,      // Speed preset, select 01
	input  wire [15:0] speedPreset2,      // Speed preset, select 10
	input  wire [15:0] speedPreset3,      // Speed preset, select 11
	input  wire [15:0] torquePreset1,     // Torque preset, select 01
	input  wire [15:0] torquePreset2,     // Torque preset, select 10
	input  wire [15:0] torquePreset3,     // Torque preset, select 11
	input  wire [15:0] pulseCmd,          // External pulse position command
	input  wire [15:0] pulseFreq,         // Pulse command frequency
	input  wire [15:0] motorSpeed,        // Measured motor speed
	input  wire [15:0] motorTorque,       // Measured motor torque
	input  wire [15:0] dcBusVoltage,      // DC bus voltage
	input  wire [15:0] maxTorque,         // Torque full scale
	input  wire [15:0] maxPulseFreq,      // Pulse frequency full scale
	input  wire [15:0] maxBusVoltage,     // Bus voltage full scale
	input  wire [15:0] regAddr,           // Register address
	input  wire        regWrite,          // Register write strobe
	input  wire        regRead,           // Register read strobe
	input  wire [15:0] regWrData,         // Register write data
	output reg  [15:0] regRdData,         // Register read data, next cycle
	output reg  [2:0]  ctrlMode,          // One-hot: torque, speed, position
	output reg         dioMapValid,       // Pin function mapping established
	output reg  [15:0] positionCmd,       // Position command
	output reg  [15:0] speedCmd,          // Speed command
	output reg  [15:0] torqueCmd,         // Torque command
	output reg         speedLimitActive,  // Speed limit applied
	output reg  [15:0] speedLimit,        // Speed limit value
	output reg         torqueLimitActive, // Torque limit applied
	output reg  [15:0] torqueLimit,       // Torque limit value
	output wire [15:0] monitorChannelOne, // Monitor one, mV
	output wire [15:0] monitorChannelTwo  // Monitor two, mV
);

	localparam [2:0] MODE_POS = 3'b001;
	localparam [2:0] MODE_SPD = 3'b010;
	localparam [2:0] MODE_TRQ = 3'b100;

	reg  [15:0] monitorChannelSelect;
	reg  [15:0] monitorOneProportion;
	reg  [15:0] monitorTwoProportion;
	reg  [7:0]  modeCode;
	reg  [2:0]  next_ctrlMode;
	reg         next_modeValid;
	reg         zeroCmdSpeedVariant;
	reg         zeroCmdTorqueVariant;
	wire [`SMMS_DI_WIDTH-1:0] diSync;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	smms_input_sync uSync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({speedTorqueSel, torquePosSel, speedPosSel, torqueSelBit1, torqueSelBit0,
			speedSelBit1, speedSelBit0}),  // RL18
		.dout  (diSync)
	);

	wire [1:0] speedSel  = {diSync[`SMMS_DI_SPEED_SEL_BIT1], diSync[`SMMS_DI_SPEED_SEL_BIT0]};
	wire [1:0] torqueSel = {diSync[`SMMS_DI_TORQUE_SEL_BIT1], diSync[`SMMS_DI_TORQUE_SEL_BIT0]};

	// ----------------------------------------
	// Command source selection
	// ----------------------------------------
	function [15:0] pickCmd;
		input [1:0]  sel;
		input        zeroVar;
		input [15:0] analog;
		input [15:0] p1;
		input [15:0] p2;
		input [15:0] p3;
		begin
			case (sel)
				2'b00: pickCmd = zeroVar ? `SMMS_ZERO16 : analog;  // RL4
				2'b01: pickCmd = p1;
				2'b10: pickCmd = p2;
				default: pickCmd = p3;
			endcase
		end
	endfunction

	function [15:0] clampSpeed;
		input [15:0] v;
		input [15:0] lim;
		reg signed [16:0] sv;
		reg signed [16:0] sl;
		reg signed [16:0] negL;
		begin
			sv = {v[15], v};
			sl = {1'b0, lim};
			negL = -sl;
			if (sv > sl)
				clampSpeed = lim;
			else if (sv < negL)
				clampSpeed = negL[15:0];
			else
				clampSpeed = v;
		end
	endfunction

	// Presets follow the select lines directly, so a change acts with no trigger
	wire [15:0] speedPick = clampSpeed(pickCmd(speedSel, zeroCmdSpeedVariant, analogSpeed,
		speedPreset1, speedPreset2, speedPreset3), maxSpeedSetting);  // RL11 RL19
	wire [15:0] torquePick = pickCmd(torqueSel, zeroCmdTorqueVariant, analogTorque,
		torquePreset1, torquePreset2, torquePreset3);  // RL19

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	always @* begin
		next_modeValid = 1'b1;
		case (modeCode)
			`SMMS_CODE_PT: next_ctrlMode = MODE_POS;
			`SMMS_CODE_S,
			`SMMS_CODE_SZ: next_ctrlMode = MODE_SPD;
			`SMMS_CODE_T,
			`SMMS_CODE_TZ: next_ctrlMode = MODE_TRQ;
			`SMMS_CODE_PT_S: next_ctrlMode = diSync[`SMMS_DI_SP] ? MODE_SPD : MODE_POS;   // RL1 RL9
			`SMMS_CODE_PT_T: next_ctrlMode = diSync[`SMMS_DI_TP] ? MODE_TRQ : MODE_POS;   // RL2 RL10
			`SMMS_CODE_S_T: next_ctrlMode = diSync[`SMMS_DI_ST] ? MODE_TRQ : MODE_SPD;    // RL3 RL7 RL8
			default: begin
				next_ctrlMode  = MODE_POS;
				next_modeValid = 1'b0;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeCode             <= `SMMS_CODE_PT;
			ctrlMode             <= MODE_POS;
			dioMapValid          <= 1'b0;
			zeroCmdSpeedVariant  <= 1'b0;
			zeroCmdTorqueVariant <= 1'b0;
		end else begin
			modeCode             <= modeSetting;
			ctrlMode             <= next_ctrlMode;
			dioMapValid          <= next_modeValid;  // RL17
			// Dual codes never select a zero-command variant
			zeroCmdSpeedVariant  <= (modeSetting == `SMMS_CODE_SZ);  // RL6
			zeroCmdTorqueVariant <= (modeSetting == `SMMS_CODE_TZ);  // RL6 RL4
		end
	end

	// ----------------------------------------
	// Commands and limits
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			positionCmd       <= `SMMS_ZERO16;
			speedCmd          <= `SMMS_ZERO16;
			torqueCmd         <= `SMMS_ZERO16;
			speedLimitActive  <= 1'b0;
			speedLimit        <= `SMMS_ZERO16;
			torqueLimitActive <= 1'b0;
			torqueLimit       <= `SMMS_ZERO16;
		end else begin
			positionCmd       <= (next_ctrlMode == MODE_POS) ? pulseCmd : `SMMS_ZERO16;   // RL9 RL10
			speedCmd          <= (next_ctrlMode == MODE_SPD) ? speedPick : `SMMS_ZERO16;  // RL7 RL9 RL11
			torqueCmd         <= (next_ctrlMode == MODE_TRQ) ? torquePick : `SMMS_ZERO16; // RL7 RL10
			speedLimitActive  <= (next_ctrlMode == MODE_TRQ) && speedLimitEnable;         // RL12
			speedLimit        <= ((next_ctrlMode == MODE_TRQ) && speedLimitEnable) ?
				speedPick : maxSpeedSetting;  // RL12 RL11
			torqueLimitActive <= (next_ctrlMode != MODE_TRQ) && torqueLimitEnable;        // RL13
			torqueLimit       <= ((next_ctrlMode != MODE_TRQ) && torqueLimitEnable) ?
				torquePick : `SMMS_ZERO16;  // RL13
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			monitorChannelSelect <= `SMMS_RST_MON_SEL;
			monitorOneProportion <= `SMMS_RST_PROP;
			monitorTwoProportion <= `SMMS_RST_PROP;
			regRdData            <= `SMMS_ZERO16;
		end else begin
			if (regWrite) begin
				case (regAddr)
					`SMMS_OFF_MON_SEL: monitorChannelSelect <= regWrData;
					`SMMS_OFF_MONITOR_CHANNEL_ONE_PROP: monitorOneProportion <= regWrData;
					`SMMS_OFF_MONITOR_CHANNEL_TWO_PROP: monitorTwoProportion <= regWrData;
					default: ;
				endcase
			end
			if (regRead) begin
				case (regAddr)
					`SMMS_OFF_MON_SEL: regRdData <= monitorChannelSelect;
					`SMMS_OFF_MONITOR_CHANNEL_ONE_PROP: regRdData <= monitorOneProportion;
					`SMMS_OFF_MONITOR_CHANNEL_TWO_PROP: regRdData <= monitorTwoProportion;
					`SMMS_OFF_STATUS: regRdData <= {10'h000, dioMapValid, torqueLimitActive,
						speedLimitActive, ctrlMode};
					default: regRdData <= `SMMS_ZERO16;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Analog monitor channels
	// ----------------------------------------
	smms_monitor_channel uMonOne (
		.clk         (clk),
		.rst_n       (rst_n),
		.sel         (monitorChannelSelect[`SMMS_MONITOR_CHANNEL_ONE_DIGIT]),  // RL15
		.proportion  (monitorOneProportion),
		.motorSpeed  (motorSpeed),
		.motorTorque (motorTorque),
		.pulseFreq   (pulseFreq),
		.speedCmd    (speedCmd),
		.torqueCmd   (torqueCmd),
		.busVoltage  (dcBusVoltage),
		.maxSpeed    (maxSpeedSetting),
		.maxTorque   (maxTorque),
		.maxPulse    (maxPulseFreq),
		.maxBus      (maxBusVoltage),
		.monOut      (monitorChannelOne)
	);

	smms_monitor_channel uMonTwo (
		.clk         (clk),
		.rst_n       (rst_n),
		.sel         (monitorChannelSelect[`SMMS_MONITOR_CHANNEL_TWO_DIGIT]),  // RL15
		.proportion  (monitorTwoProportion),
		.motorSpeed  (motorSpeed),
		.motorTorque (motorTorque),
		.pulseFreq   (pulseFreq),
		.speedCmd    (speedCmd),
		.torqueCmd   (torqueCmd),
		.busVoltage  (dcBusVoltage),
		.maxSpeed    (maxSpeedSetting),
		.maxTorque   (maxTorque),
		.maxPulse    (maxPulseFreq),
		.maxBus      (maxBusVoltage),
		.monOut      (monitorChannelTwo)
	);

endmodule // smms_mode_select
`default_nettype wire

// ### verilog/smms_monitor_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "smms_defines.vh"

module smms_monitor_channel (
	input  wire        clk,         // System clock
	input  wire        rst_n,       // Asynchronous reset, active low
	input  wire [3:0]  sel,         // Quantity selector digit
	input  wire [15:0] proportion,  // Full-scale proportion, percent
	input  wire [15:0] motorSpeed,  // Signed motor speed
	input  wire [15:0] motorTorque, // Signed motor torque
	input  wire [15:0] pulseFreq,   // Pulse command frequency
	input  wire [15:0] speedCmd,    // Signed speed command
	input  wire [15:0] torqueCmd,   // Signed torque command
	input  wire [15:0] busVoltage,  // DC bus voltage
	input  wire [15:0] maxSpeed,    // Speed full scale
	input  wire [15:0] maxTorque,   // Torque full scale
	input  wire [15:0] maxPulse,    // Pulse frequency full scale
	input  wire [15:0] maxBus,      // Bus voltage full scale
	output reg  [15:0] monOut       // Signed output, millivolts
);

	reg  [15:0]        q;
	reg  [15:0]        qMax;

	// ----------------------------------------
	// Quantity selection
	// ----------------------------------------
	always @* begin
		case (sel)
			`SMMS_MON_SPEED: begin q = motorSpeed; qMax = maxSpeed; end     // RL14
			`SMMS_MON_TORQUE: begin q = motorTorque; qMax = maxTorque; end  // RL14
			`SMMS_MON_PULSE: begin q = pulseFreq; qMax = maxPulse; end      // RL14
			`SMMS_MON_SPD_CMD: begin q = speedCmd; qMax = maxSpeed; end     // RL14
			`SMMS_MON_TRQ_CMD: begin q = torqueCmd; qMax = maxTorque; end   // RL14
			`SMMS_MON_BUS: begin q = busVoltage; qMax = maxBus; end         // RL14
			default: begin q = `SMMS_ZERO16; qMax = `SMMS_ZERO16; end       // RL14
		endcase
	end

	// ----------------------------------------
	// Scaling: 8 V * q / (max * prop / 100)
	// ----------------------------------------
	wire signed [39:0] qWide    = {{24{q[15]}}, q};
	wire signed [79:0] prodFull = qWide * $signed(`SMMS_MON_NUM);
	wire signed [39:0] num      = prodFull[39:0];
	wire        [31:0] denU     = qMax * proportion;
	wire signed [39:0] den      = {8'h00, denU};
	// A zero full scale or proportion would divide by zero, so it reads as 0 V
	wire signed [39:0] quo      = (denU == 32'h00000000) ? 40'sh0000000000 : num / den; // RL16
	// Clamp levels held at full width so only their low word reaches the output
	wire        [39:0] limPos   = `SMMS_MON_LIM_POS;
	wire        [39:0] limNeg   = `SMMS_MON_LIM_NEG;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			monOut <= `SMMS_ZERO16;
		end else if (quo > `SMMS_MON_LIM_POS) begin
			monOut <= limPos[15:0];
		end else if (quo < `SMMS_MON_LIM_NEG) begin
			monOut <= limNeg[15:0];
		end else begin
			monOut <= quo[15:0];  // RL16
		end
	end

endmodule // smms_monitor_channel
`default_nettype wire
